// *** design/tha_pkg.sv ***
`default_nettype none
// ======================================================================
// Threshold alert package
package tha_pkg;

    // Command bytes
    localparam logic [7:0] CMD_PFX_WR   = 8'h61;
    localparam logic [7:0] CMD_PFX_RD   = 8'he1;
    localparam logic [7:0] CMD_WR_SETHI = 8'h1d;
    localparam logic [7:0] CMD_WR_CLRHI = 8'h16;
    localparam logic [7:0] CMD_WR_SETLO = 8'h00;
    localparam logic [7:0] CMD_WR_CLRLO = 8'h0b;
    localparam logic [7:0] CMD_WR_CFG   = 8'hbb;
    localparam logic [7:0] CMD_RD_SETHI = 8'h1f;
    localparam logic [7:0] CMD_RD_CLRHI = 8'h14;
    localparam logic [7:0] CMD_RD_SETLO = 8'h02;
    localparam logic [7:0] CMD_RD_CLRLO = 8'h09;

    // Threshold slots
    localparam logic [1:0] TH_SETHI = 2'h0;
    localparam logic [1:0] TH_CLRHI = 2'h1;
    localparam logic [1:0] TH_SETLO = 2'h2;
    localparam logic [1:0] TH_CLRLO = 2'h3;

    // Threshold reset values
    localparam logic [15:0] TH_SETHI_RST = 16'hcd33;
    localparam logic [15:0] TH_CLRHI_RST = 16'hc92d;
    localparam logic [15:0] TH_SETLO_RST = 16'h3466;
    localparam logic [15:0] TH_CLRLO_RST = 16'h3869;

    // Field layout: humidity in the top 7 bits, temperature below
    localparam int TH_RH_W   = 7;
    localparam int TH_T_W    = 9;
    localparam int TH_RH_LSB = 9;
    localparam int MEAS_RH_LSB = 16 - TH_RH_W;
    localparam int MEAS_T_LSB  = 16 - TH_T_W;

    // Status bits feeding the alert pin
    localparam int ST_ANY = 15;
    localparam int ST_RH  = 11;
    localparam int ST_T   = 10;
    localparam int ST_RST = 4;
    localparam logic [15:0] STATUS_RST = 16'h0010;

    // Checksum
    localparam logic [7:0] CRC_POLY = 8'h31;
    localparam logic [7:0] CRC_INIT = 8'hff;

    // Serial slave states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX   = 3'b001,
        ST_RACK = 3'b010,
        ST_TX   = 3'b011,
        ST_TACK = 3'b100,
        ST_WAIT = 3'b101
    } tha_i2c_e;

endpackage : tha_pkg
`default_nettype wire

// *** design/tha_crc8.sv ***
`default_nettype none
// ======================================================================
// Checksum over one 16-bit word, most significant bit first
module tha_crc8
    import tha_pkg::*;
(
    input  wire logic [15:0] data, // Word to protect
    output logic      [7:0]  crc   // Checksum byte
);

    // Bitwise shift through the polynomial
    always_comb begin
        crc = CRC_INIT;
        for (int i = 15; i >= 0; i--) begin
            if (crc[7] ^ data[i]) begin
                crc = {crc[6:0], 1'b0} ^ CRC_POLY;
            end else begin
                crc = {crc[6:0], 1'b0};
            end
        end
    end

endmodule : tha_crc8
`default_nettype wire

// *** design/tha_alert.sv ***
`default_nettype none
module tha_alert
    import tha_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h44 // Slave address
)(
    input  wire logic        ref_clk,      // 20 MHz clock
    input  wire logic        resetn,       // Sync reset, active low
    input  wire logic        soft_reset,   // Soft reset pulse
    input  wire logic        scl_in,       // Serial clock pin
    input  wire logic        sda_in,       // Serial data pin
    output logic             sda_out,      // Data pin level when driven
    output logic             sda_oe_n,     // Data drive, active low
    input  wire logic        meas_valid,   // Measurement done pulse
    input  wire logic [15:0] meas_temp,    // Temperature code
    input  wire logic [15:0] meas_rh,      // Humidity code
    input  wire logic        status_clear, // Clear status pulse
    output logic      [15:0] status,       // Status register
    output logic             alert,        // Alert pin, active high
    input  wire logic [15:0] nv_cfg_in,    // Stored start-up config
    output logic             nv_wr,        // Store config pulse
    output logic      [15:0] nv_data,      // Config word to store
    output logic             auto_mode     // Start in auto mode
);

    // ==================================================================
    // Elaboration check
    if (DEV_ADDR == 7'h00) begin : g_chk
        $error("DEV_ADDR must not be the general call address");
    end

    // ==================================================================
    // State
    typedef struct packed {
        logic [1:0]       scl_s;
        logic [1:0]       sda_s;
        logic             scl_d;
        logic             sda_d;
        tha_i2c_e         fsm;
        logic [3:0]       bits;
        logic [2:0]       idx;
        logic             rw;
        logic             mack;
        logic [7:0]       sh;
        logic [7:0]       cmd0;
        logic [7:0]       cmd1;
        logic [7:0]       dmsb;
        logic [7:0]       dlsb;
        logic             drive_low;
        logic [3:0][15:0] th;
        logic [1:0]       rd_sel;
        logic             t_hi;
        logic             t_lo;
        logic             rh_hi;
        logic             rh_lo;
        logic [15:0]      status;
        logic             alert;
        logic             boot;
        logic             auto_mode;
        logic             nv_wr;
        logic [15:0]      nv_data;
    } tha_state_s;

    tha_state_s s;
    tha_state_s nx;

    logic [7:0] crc_rx;
    logic [7:0] crc_tx;

    // ==================================================================
    // Helpers
    function automatic logic [TH_T_W-1:0] f_t(input logic [15:0] w);
        f_t = w[TH_T_W-1:0];
    endfunction : f_t

    function automatic logic [TH_RH_W-1:0] f_rh(input logic [15:0] w);
        f_rh = w[15:TH_RH_LSB];
    endfunction : f_rh

    // Hysteresis step: raise past set, drop past clear, else hold
    function automatic logic f_step(input logic cur, input logic en,
                                    input logic set, input logic rel);
        if (!en) begin
            f_step = 1'b0;
        end else if (set) begin
            f_step = 1'b1;
        end else if (rel) begin
            f_step = 1'b0;
        end else begin
            f_step = cur;
        end
    endfunction : f_step

    // Checksum of received data and of the word to send
    tha_crc8 u_crc_rx (
        .data ({s.dmsb, s.dlsb}),
        .crc  (crc_rx)
    );
    tha_crc8 u_crc_tx (
        .data (s.th[s.rd_sel]),
        .crc  (crc_tx)
    );

    // Truncated measurement fields and tracking enables
    logic [TH_T_W-1:0]  m_t;
    logic [TH_RH_W-1:0] m_rh;
    logic               t_en;
    logic               rh_en;
    logic               cfg_nz;
    assign m_t    = meas_temp[15:MEAS_T_LSB];
    assign m_rh   = meas_rh[15:MEAS_RH_LSB];
    assign t_en   = f_t(s.th[TH_SETHI]) >= f_t(s.th[TH_SETLO]);
    assign rh_en  = f_rh(s.th[TH_SETHI]) >= f_rh(s.th[TH_SETLO]);
    assign cfg_nz = nv_cfg_in != 16'h0000;

    // ==================================================================
    // Next state
    logic       scl;
    logic       sda;
    logic       scl_rise;
    logic       scl_fall;
    logic       start;
    logic       stop;
    logic       ack;
    logic [7:0] txb;
    logic       bad_crc;
    logic       alert_c;

    always_comb begin
        nx       = s;
        ack      = 1'b0;
        bad_crc  = 1'b0;
        nx.nv_wr = 1'b0;
        scl      = s.scl_s[1];
        sda      = s.sda_s[1];
        scl_rise = scl & ~s.scl_d;
        scl_fall = ~scl & s.scl_d;
        start    = scl & s.scl_d & s.sda_d & ~sda;
        stop     = scl & s.scl_d & ~s.sda_d & sda;
        nx.scl_s = {s.scl_s[0], scl_in};
        nx.sda_s = {s.sda_s[0], sda_in};
        nx.scl_d = scl;
        nx.sda_d = sda;
        // Byte to send for the current read slot
        unique case (s.idx)
            3'd0:    txb = s.th[s.rd_sel][15:8];
            3'd1:    txb = s.th[s.rd_sel][7:0];
            3'd2:    txb = crc_tx;
            default: txb = 8'hff;
        endcase

        // Serial slave; thresholds reachable in any mode
        if (stop) begin
            nx.fsm       = ST_IDLE;
            nx.drive_low = 1'b0;
        end else if (start) begin
            nx.fsm       = ST_RX;
            nx.bits      = 4'd0;
            nx.idx       = 3'd0;
            nx.drive_low = 1'b0;
        end else begin
            unique case (s.fsm)
                ST_IDLE, ST_WAIT: begin
                    nx.drive_low = 1'b0;
                end
                ST_RX: begin
                    if (scl_rise) begin
                        nx.sh   = {s.sh[6:0], sda};
                        nx.bits = s.bits + 4'd1;
                    end else if (scl_fall && s.bits == 4'd8) begin
                        nx.bits = 4'd0;
                        nx.fsm  = ST_RACK;
                        if (s.idx != 3'd7) begin
                            nx.idx = s.idx + 3'd1;
                        end
                        unique case (s.idx)
                            3'd0: begin
                                ack   = s.sh[7:1] == DEV_ADDR;
                                nx.rw = s.sh[0];
                                if (s.sh[0]) begin
                                    nx.idx = 3'd0;
                                end
                            end
                            3'd1: begin
                                nx.cmd0 = s.sh;
                                ack = s.sh == CMD_PFX_WR
                                    || s.sh == CMD_PFX_RD;
                            end
                            3'd2: begin
                                nx.cmd1 = s.sh;
                                ack     = 1'b1;
                                if (s.cmd0 == CMD_PFX_RD) begin
                                    unique case (s.sh)
                                        CMD_RD_SETHI: nx.rd_sel = TH_SETHI;
                                        CMD_RD_CLRHI: nx.rd_sel = TH_CLRHI;
                                        CMD_RD_SETLO: nx.rd_sel = TH_SETLO;
                                        CMD_RD_CLRLO: nx.rd_sel = TH_CLRLO;
                                        default:      ack = 1'b0;
                                    endcase
                                end
                            end
                            3'd3: begin
                                nx.dmsb = s.sh;
                                ack     = s.cmd0 == CMD_PFX_WR;
                            end
                            3'd4: begin
                                nx.dlsb = s.sh;
                                ack     = 1'b1;
                            end
                            3'd5: begin
                                ack     = crc_rx == s.sh;
                                bad_crc = !ack;
                                if (ack) begin
                                    unique case (s.cmd1)
                                        CMD_WR_SETHI: nx.th[TH_SETHI] =
                                            {s.dmsb, s.dlsb};
                                        CMD_WR_CLRHI: nx.th[TH_CLRHI] =
                                            {s.dmsb, s.dlsb};
                                        CMD_WR_SETLO: nx.th[TH_SETLO] =
                                            {s.dmsb, s.dlsb};
                                        CMD_WR_CLRLO: nx.th[TH_CLRLO] =
                                            {s.dmsb, s.dlsb};
                                        CMD_WR_CFG: begin
                                            nx.nv_wr   = 1'b1;
                                            nx.nv_data = {s.dmsb, s.dlsb};
                                        end
                                        default: ack = 1'b0;
                                    endcase
                                end
                            end
                            default: ack = 1'b0;
                        endcase
                        nx.drive_low = ack;
                    end
                end
                ST_RACK: begin
                    if (scl_fall) begin
                        nx.drive_low = 1'b0;
                        if (!s.drive_low) begin
                            nx.fsm = ST_WAIT;
                        end else if (s.rw) begin
                            nx.fsm       = ST_TX;
                            nx.sh        = txb;
                            nx.bits      = 4'd0;
                            nx.drive_low = ~txb[7];
                        end else begin
                            nx.fsm = ST_RX;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (s.bits == 4'd7) begin
                            nx.drive_low = 1'b0;
                            nx.fsm       = ST_TACK;
                            nx.idx       = s.idx + 3'd1;
                        end else begin
                            nx.sh        = {s.sh[6:0], 1'b1};
                            nx.drive_low = ~s.sh[6];
                            nx.bits      = s.bits + 4'd1;
                        end
                    end
                end
                ST_TACK: begin
                    if (scl_rise) begin
                        nx.mack = ~sda;
                    end else if (scl_fall) begin
                        if (s.mack) begin
                            nx.fsm       = ST_TX;
                            nx.sh        = txb;
                            nx.bits      = 4'd0;
                            nx.drive_low = ~txb[7];
                        end else begin
                            nx.fsm = ST_WAIT;
                        end
                    end
                end
                default: begin
                    nx.fsm       = ST_IDLE;
                    nx.drive_low = 1'b0;
                end
            endcase
        end

        // Clear first, so a measurement in the same cycle still sets
        if (status_clear) begin
            nx.status = 16'h0000;
            nx.t_hi   = 1'b0;
            nx.t_lo   = 1'b0;
            nx.rh_hi  = 1'b0;
            nx.rh_lo  = 1'b0;
        end
        // Independent hysteresis per quantity and bound
        if (meas_valid) begin
            nx.t_hi  = f_step(nx.t_hi, t_en,
                m_t > f_t(s.th[TH_SETHI]),
                m_t < f_t(s.th[TH_CLRHI]));
            nx.t_lo  = f_step(nx.t_lo, t_en,
                m_t < f_t(s.th[TH_SETLO]),
                m_t > f_t(s.th[TH_CLRLO]));
            nx.rh_hi = f_step(nx.rh_hi, rh_en,
                m_rh > f_rh(s.th[TH_SETHI]),
                m_rh < f_rh(s.th[TH_CLRHI]));
            nx.rh_lo = f_step(nx.rh_lo, rh_en,
                m_rh < f_rh(s.th[TH_SETLO]),
                m_rh > f_rh(s.th[TH_CLRLO]));
            nx.status[ST_T]  = nx.t_hi | nx.t_lo;
            nx.status[ST_RH] = nx.rh_hi | nx.rh_lo;
        end
        nx.status[ST_ANY] = nx.status[ST_T] | nx.status[ST_RH];

        // Alert mirrors the selected bits; a drop wipes status
        alert_c = nx.status[ST_ANY] | nx.status[ST_RH]
                | nx.status[ST_T] | nx.status[ST_RST];
        nx.alert = alert_c;
        if (s.alert && !alert_c) begin
            nx.status = 16'h0000;
        end

        // Start-up mode caught one cycle after reset release
        if (s.boot) begin
            nx.auto_mode = cfg_nz;
            nx.boot      = 1'b0;
        end

        // Soft reset and hardware reset restore defaults
        if (!resetn || soft_reset) begin
            nx.th[TH_SETHI] = TH_SETHI_RST;
            nx.th[TH_CLRHI] = TH_CLRHI_RST;
            nx.th[TH_SETLO] = TH_SETLO_RST;
            nx.th[TH_CLRLO] = TH_CLRLO_RST;
            nx.status       = STATUS_RST;
            nx.alert        = 1'b1;
            nx.t_hi         = 1'b0;
            nx.t_lo         = 1'b0;
            nx.rh_hi        = 1'b0;
            nx.rh_lo        = 1'b0;
            nx.boot         = 1'b1;
            nx.nv_wr        = 1'b0;
        end
        if (!resetn) begin
            nx           = '0;
            nx.fsm       = ST_IDLE;
            nx.scl_s     = 2'h3;
            nx.sda_s     = 2'h3;
            nx.scl_d     = 1'b1;
            nx.sda_d     = 1'b1;
            nx.th[TH_SETHI] = TH_SETHI_RST;
            nx.th[TH_CLRHI] = TH_CLRHI_RST;
            nx.th[TH_SETLO] = TH_SETLO_RST;
            nx.th[TH_CLRLO] = TH_CLRLO_RST;
            nx.status    = STATUS_RST;
            nx.alert     = 1'b0;
            nx.boot      = 1'b1;
        end
    end

    // ==================================================================
    // Registers and outputs
    always_ff @(posedge ref_clk) begin
        s <= nx;
    end

    assign sda_out   = 1'b0 & s.drive_low;
    assign sda_oe_n  = ~s.drive_low;
    assign status    = s.status;
    assign alert     = s.alert;
    assign nv_wr     = s.nv_wr;
    assign nv_data   = s.nv_data;
    assign auto_mode = s.auto_mode;

    // ==================================================================
    // Assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence seq_boot;
        s.boot && !soft_reset;
    endsequence
    sequence seq_crc_fail;
        bad_crc && !soft_reset && !start && !stop;
    endsequence

    AST_START_MODE: assert property (seq_boot ##1 1'b1 |->
        auto_mode == $past(cfg_nz))
        else $error("start-up mode not taken from stored config");
    AST_CFG_STORE: assert property (nv_wr |->
        $past(s.cmd1) == CMD_WR_CFG && sda_oe_n == 1'b0)
        else $error("config store without acknowledged command");
    AST_ALERT_MIRROR: assert property ($past(resetn) |-> alert ==
        (status[ST_ANY] | status[ST_RH] | status[ST_T] | status[ST_RST]))
        else $error("alert pin does not mirror status bits");
    AST_RESET_ALERT: assert property ($rose(resetn) |->
        !alert ##1 alert && status == STATUS_RST)
        else $error("alert not raised after reset release");
    AST_DROP_CLEAR: assert property ($fell(alert) |->
        status == 16'h0000)
        else $error("status not cleared when alert dropped");
    AST_T_SET_HI: assert property (meas_valid && t_en && !soft_reset
        && m_t > f_t(s.th[TH_SETHI]) |=> s.t_hi && status[ST_T])
        else $error("temperature high alarm not raised");
    AST_T_REL_HI: assert property (meas_valid && !soft_reset
        && m_t < f_t(s.th[TH_CLRHI]) && m_t <= f_t(s.th[TH_SETHI])
        |=> !s.t_hi)
        else $error("temperature high alarm not released");
    AST_RH_SET_LO: assert property (meas_valid && rh_en
        && !soft_reset && m_rh < f_rh(s.th[TH_SETLO])
        |=> s.rh_lo && alert)
        else $error("humidity low alarm not raised");
    AST_RH_REL_LO: assert property (meas_valid && !soft_reset
        && m_rh > f_rh(s.th[TH_CLRLO]) && m_rh >= f_rh(s.th[TH_SETLO])
        |=> !s.rh_lo)
        else $error("humidity low alarm not released");
    AST_SOFT_DEFAULTS: assert property (soft_reset |=>
        s.th[TH_SETHI] == TH_SETHI_RST && s.th[TH_CLRLO] == TH_CLRLO_RST)
        else $error("thresholds not restored by soft reset");
    AST_BAD_CRC: assert property (seq_crc_fail |=>
        sda_oe_n && $stable(s.th))
        else $error("bad checksum acknowledged or stored");
    AST_T_DISABLED: assert property (meas_valid && !t_en |=>
        !s.t_hi && !s.t_lo)
        else $error("disabled temperature tracking raised alarm");

endmodule : tha_alert
`default_nettype wire

// *** dv/tha_i2c_ctl.sv ***
`default_nettype none
// ======================================================================
// Serial controller model, releases the data line when not pulling low
module tha_i2c_ctl #(
    parameter logic [6:0] ADDR = 7'h44 // Target address
)(
    output logic      scl,     // Serial clock, idles high
    output logic      sda_m,   // Data drive, 1 = released
    input  wire logic sda_line // Resolved data line
);
    timeunit 1ns;
    timeprecision 1ns;
    // Bus idle
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    // One byte MSB first, then the acknowledge slot
    task automatic put(input logic [7:0] b, inout logic [5:0] a);
        for (int i = 7; i >= -1; i--) begin
            sda_m = (i < 0) ? 1'b1 : b[i & 7];
            #100 scl = 1'b1;
            if (i < 0) a = {a[4:0], ~sda_line};
            #200 scl = 1'b0;
            #100;
        end
    endtask : put
    // Write frame: prefix, code, word, checksum
    task automatic frame(input logic [7:0] code, input logic [15:0] w,
                         input logic [7:0] c, output logic [5:0] a);
        a = 6'h00;
        #200 sda_m = 1'b0;
        #200 scl = 1'b0;
        #100;
        put({ADDR, 1'b0}, a);
        put(8'h61, a);
        put(code, a);
        put(w[15:8], a);
        put(w[7:0], a);
        put(c, a);
        sda_m = 1'b0;
        #100 scl = 1'b1;
        #200 sda_m = 1'b1;
        #200;
    endtask : frame
    // Read frame: prefix, code, repeated start, word and checksum
    task automatic rd(input logic [7:0] code, output logic [23:0] d,
                      output logic [5:0] a);
        a = 6'h00;
        d = 24'h000000;
        #200 sda_m = 1'b0;
        #200 scl = 1'b0;
        #100;
        put({ADDR, 1'b0}, a);
        put(8'he1, a);
        put(code, a);
        sda_m = 1'b1;
        #100 scl = 1'b1;
        #200 sda_m = 1'b0;
        #200 scl = 1'b0;
        #100;
        put({ADDR, 1'b1}, a);
        // Three bytes in, acknowledging all but the last
        for (int j = 0; j < 27; j++) begin
            sda_m = (j % 9 != 8) || (j == 26);
            #100 scl = 1'b1;
            if (j % 9 != 8) d = {d[22:0], sda_line};
            #200 scl = 1'b0;
            #100;
        end
        sda_m = 1'b0;
        #100 scl = 1'b1;
        #200 sda_m = 1'b1;
        #200;
    endtask : rd
endmodule : tha_i2c_ctl
`default_nettype wire

// *** dv/testbench.sv ***
`default_nettype none
// ======================================================================
// Self-checking bench for the threshold alert block
module testbench import tha_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic        ref_clk = 1'b0, resetn = 1'b0, soft_reset = 1'b0;
    logic        meas_valid = 1'b0, status_clear = 1'b0;
    logic [15:0] meas_temp = '0, meas_rh = '0, nv_cfg_in = '0;
    wire logic   scl, sda_m, sda_out, sda_oe_n, alert, nv_wr, auto_mode;
    wire logic   [15:0] status, nv_data;
    wire logic   sda = sda_m & (sda_oe_n | sda_out); // Pulled up line
    int          mismatches = 0, num_checks = 0, cycles = 0, nv_cnt = 0;
    integer      seed = 32'hc4ff8d45;
    logic [5:0]  acks;
    tha_alert tha_alert_inst (.ref_clk, .resetn, .soft_reset,
        .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe_n, .meas_valid,
        .meas_temp, .meas_rh, .status_clear, .status, .alert,
        .nv_cfg_in, .nv_wr, .nv_data, .auto_mode);
    tha_i2c_ctl tha_i2c_ctl_inst (.scl, .sda_m, .sda_line(sda));
    // Clock
    always #25 ref_clk = ~ref_clk;
    // Hang guard and store pulse count
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (nv_wr) nv_cnt <= nv_cnt + 1;
        if (cycles == 20000) begin
            mismatches++;
            close_out();
        end
    end
    task automatic chk(input string n, input logic [15:0] e, g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : close_out
    function automatic logic [7:0] crc8(input logic [15:0] w);
        logic [7:0] c;
        c = 8'hff;
        for (int i = 15; i >= 0; i--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
        return c;
    endfunction : crc8
    task automatic rst(input logic am);
        @(negedge ref_clk);
        resetn = 1'b0;
        repeat (2) @(negedge ref_clk);
        chk("alert", 16'h0, {15'h0, alert});
        resetn = 1'b1;
        @(negedge ref_clk);
        chk("status", 16'h0010, status);
        chk("alert", 16'h1, {15'h0, alert});
        chk("auto", {15'h0, am}, {15'h0, auto_mode});
    endtask : rst
    task automatic meas(input logic [8:0] t, input logic [6:0] h,
                        input logic [15:0] st);
        @(negedge ref_clk);
        meas_valid = 1'b1;
        meas_temp = {t, 7'($random(seed))};
        meas_rh = {h, 9'($random(seed))};
        @(negedge ref_clk);
        meas_valid = 1'b0;
        chk("status", st, status);
        chk("alert", {15'h0, |st}, {15'h0, alert});
    endtask : meas
    task automatic clr();
        @(negedge ref_clk);
        status_clear = 1'b1;
        @(negedge ref_clk);
        status_clear = 1'b0;
        chk("cleared", 16'h0, {status[14:0], alert});
    endtask : clr
    task automatic wr(input logic [7:0] cd, input logic [15:0] w,
                      input logic bad);
        tha_i2c_ctl_inst.frame(cd, w, crc8(w) ^ {7'h0, bad}, acks);
        chk("acks", {10'h0, 5'h1f, ~bad}, {10'h0, acks});
    endtask : wr
    task automatic rdc(input logic [7:0] cd, input logic [15:0] w);
        logic [23:0] d;
        tha_i2c_ctl_inst.rd(cd, d, acks);
        chk("rd_acks", 16'h000f, {10'h0, acks});
        chk("rd_word", w, d[23:8]);
        chk("rd_crc", {8'h0, crc8(w)}, {8'h0, d[7:0]});
    endtask : rdc
    initial begin
        rst(1'b0);
        clr();
        rdc(8'h09, 16'h3869);
        meas(9'h133, 7'h66, 16'h0000);
        meas(9'h134, 7'h40, 16'h8400);
        meas(9'h12d, 7'h40, 16'h8400);
        meas(9'h12c, 7'h40, 16'h0000);
        meas(9'h065, 7'h40, 16'h8400);
        meas(9'h069, 7'h40, 16'h8400);
        meas(9'h06a, 7'h67, 16'h8800);
        meas(9'h100, 7'h19, 16'h8800);
        meas(9'h100, 7'h40, 16'h0000);
        repeat (40) meas(9'(32'h6a + {$random(seed)} % 195),
                         7'(32'h1d + {$random(seed)} % 72), 16'h0);
        $display("threshold tracking done");
        wr(8'h1d, 16'he741, 1'b1);
        meas(9'h134, 7'h40, 16'h8400);
        clr();
        wr(8'h1d, 16'he741, 1'b0);
        rdc(8'h1f, 16'he741);
        meas(9'h141, 7'h73, 16'h0000);
        meas(9'h142, 7'h40, 16'h8400);
        wr(8'h16, 16'h1234, 1'b0);
        rdc(8'h14, 16'h1234);
        @(negedge ref_clk) soft_reset = 1'b1;
        @(negedge ref_clk) soft_reset = 1'b0;
        chk("status", 16'h0010, status);
        rdc(8'h14, 16'hc92d);
        clr();
        meas(9'h134, 7'h40, 16'h8400);
        clr();
        wr(8'h1d, 16'h0000, 1'b0);
        meas(9'h1ff, 7'h7f, 16'h0000);
        meas(9'h000, 7'h00, 16'h0000);
        $display("serial writes done");
        wr(8'hbb, 16'h0001, 1'b0);
        chk("nv_data", 16'h0001, nv_data);
        chk("nv_wr", 16'h1, 16'(nv_cnt));
        nv_cfg_in = 16'h0001;
        rst(1'b1);
        $display("start-up mode done");
        close_out();
    end
endmodule : testbench
`default_nettype wire
